// ### rtl/ulm_map.vh
// Register offsets, field positions and reset values of the line-mode block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef ULM_MAP_VH
`define ULM_MAP_VH

// ==========================================================================
// Register byte offsets
`define ULM_OFF_COMMAND 8'h00
`define ULM_OFF_LINECFG 8'h04
`define ULM_OFF_STATUS 8'h14
`define ULM_OFF_BAUD 8'h20
`define ULM_OFF_RATIO 8'h40
`define ULM_OFF_IRFILT 8'h4C

// ==========================================================================
// Line configuration fields
`define ULM_LINE_MODE_LSB 0
`define ULM_LINE_MODE_MSB 3
`define ULM_CHAN_MODE_LSB 14
`define ULM_CHAN_MODE_MSB 15
`define ULM_MODE_NORMAL 4'h0
`define ULM_MODE_RS485 4'h1
`define ULM_MODE_MODEM 4'h3
`define ULM_MODE_IRDA 4'h8
`define ULM_CHAN_NORMAL 2'h0
`define ULM_CHAN_ECHO 2'h1
`define ULM_CHAN_LOCAL 2'h2
`define ULM_CHAN_REMOTE 2'h3

// ==========================================================================
// Command bits
`define ULM_CMD_DTR_ON 16
`define ULM_CMD_DTR_OFF 17
`define ULM_CMD_RTS_ON 18
`define ULM_CMD_RTS_OFF 19

// ==========================================================================
// Channel status bits
`define ULM_ST_TXDONE 9
`define ULM_ST_CHG_LSB 16
`define ULM_ST_LVL_LSB 20

// ==========================================================================
// Reset values and timing
`define ULM_RATIO_RESET 11'h174
`define ULM_OVERSAMPLE 16
`define ULM_PULSE_SIXTEENTHS 3

`endif

// ### rtl/ulm_line_modes.v
// Line-mode logic of a serial port: infrared codec, RS485 and modem lines,
// channel test modes, APB register slave.
// Assumes a character engine on the same clock supplies the raw transmit
// line, the transmitter-all-done flag (timeguard included) and tx enable.
//
// Overview of operation
// - Infrared zero bit is a 3/16 pulse
// - Demodulator has 8-bit filter down counter
// - Falling receive edge starts counting each clock
// - Rising edge stops and reloads the counter
// - Counter at zero drives receiver low one bit
// - Line mode 0x1 selects RS485
// - RS485 request-to-send is inverse of all-done
// - Request-to-send stays high through timeguard
// - Line mode 0x3 selects modem terminal mode
// - Terminal-ready commands force high or low
// - Modem input changes set status flags
// - Status read clears modem change flags
// - Clear-to-send high stops tx after character
// - Modem mode drives request-to-send automatically
// - Normal channel: pins straight to engine
// - Echo: receive pin retransmitted, receiver active
// - Local loopback: tx to rx, pin idle high
// - Remote loopback: rx pin to tx pin
// - Line mode 0x8 selects infrared codec
`timescale 1ns/1ps
`include "ulm_map.vh"

module ulm_line_modes #(
	parameter FILTER_WIDTH = 8,
	parameter DIVISOR_WIDTH = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire engineTxLine,
	input wire engineTxAllDone,
	input wire engineTxEnabled,
	output reg engineRxLine,
	output reg engineTxInhibit,
	output reg engineDisable,
	output wire [DIVISOR_WIDTH-1:0] baudDivisor,
	output wire [10:0] clockRatio,
	input wire rxdPin,
	input wire riPin,
	input wire dsrPin,
	input wire dcdPin,
	input wire ctsPin,
	output reg txdPin,
	output reg rtsPin,
	output reg dtrPin
);

localparam CNT_WIDTH = DIVISOR_WIDTH + 4;

// ==========================================================================
// Pin synchronisers
reg [4:0] pinMeta_q;
reg [4:0] pinSync_q;
reg [4:0] pinLast_q;
wire rxSync;
wire [3:0] modemSync;

always @(posedge clk) begin
	if (sys_rst) begin
		pinMeta_q <= 5'h1F;
		pinSync_q <= 5'h1F;
		pinLast_q <= 5'h1F;
	end else begin
		pinMeta_q <= {ctsPin, dcdPin, dsrPin, riPin, rxdPin};
		pinSync_q <= pinMeta_q;
		pinLast_q <= pinSync_q;
	end
end

assign rxSync = pinSync_q[0];
// Order: ring, set-ready, carrier, clear-to-send
assign modemSync = pinSync_q[4:1];

// ==========================================================================
// Registers
reg [3:0] lineMode_q;
reg [1:0] chanMode_q;
reg [DIVISOR_WIDTH-1:0] baud_q;
reg [10:0] ratio_q;
reg [FILTER_WIDTH-1:0] irFilter_q;
reg [3:0] modemChg_q;
reg [3:0] modemChg_d;
reg dtrLevel_q;
reg rtsCmd_q;

wire setupPhase = psel & ~penable;
wire accessPhase = psel & penable;
wire wrAccess = accessPhase & pwrite;
wire statusRead = accessPhase & ~pwrite & (paddr == `ULM_OFF_STATUS);
wire modemMode = (lineMode_q == `ULM_MODE_MODEM);
wire rs485Mode = (lineMode_q == `ULM_MODE_RS485);
wire irdaMode = (lineMode_q == `ULM_MODE_IRDA);
wire addrMapped = (paddr == `ULM_OFF_COMMAND) | (paddr == `ULM_OFF_LINECFG) |
	(paddr == `ULM_OFF_STATUS) | (paddr == `ULM_OFF_BAUD) |
	(paddr == `ULM_OFF_RATIO) | (paddr == `ULM_OFF_IRFILT);

// Zero wait states; data captured in the setup cycle
assign pready = 1'b1;
assign baudDivisor = baud_q;
assign clockRatio = ratio_q;

always @(posedge clk) begin
	if (sys_rst) begin
		lineMode_q <= `ULM_MODE_NORMAL;
		chanMode_q <= `ULM_CHAN_NORMAL;
		baud_q <= {DIVISOR_WIDTH{1'b0}};
		ratio_q <= `ULM_RATIO_RESET;
		irFilter_q <= {FILTER_WIDTH{1'b0}};
	end else if (wrAccess) begin
		case (paddr)
			`ULM_OFF_LINECFG: begin
				lineMode_q <= pwdata[`ULM_LINE_MODE_MSB:`ULM_LINE_MODE_LSB];
				chanMode_q <= pwdata[`ULM_CHAN_MODE_MSB:`ULM_CHAN_MODE_LSB];
			end
			`ULM_OFF_BAUD: baud_q <= pwdata[DIVISOR_WIDTH-1:0];
			`ULM_OFF_RATIO: ratio_q <= pwdata[10:0];
			`ULM_OFF_IRFILT: irFilter_q <= pwdata[FILTER_WIDTH-1:0];
			default: baud_q <= baud_q;
		endcase
	end
end

// Terminal-ready and manual request-to-send; off wins if both written
always @(posedge clk) begin
	if (sys_rst) begin
		dtrLevel_q <= 1'b1;
		rtsCmd_q <= 1'b1;
	end else if (wrAccess && paddr == `ULM_OFF_COMMAND) begin
		if (pwdata[`ULM_CMD_DTR_OFF])
			dtrLevel_q <= 1'b1;
		else if (pwdata[`ULM_CMD_DTR_ON])
			dtrLevel_q <= 1'b0;
		if (pwdata[`ULM_CMD_RTS_OFF])
			rtsCmd_q <= 1'b1;
		else if (pwdata[`ULM_CMD_RTS_ON])
			rtsCmd_q <= 1'b0;
	end
end

// ==========================================================================
// Modem change flags
wire [3:0] modemEdge = pinSync_q[4:1] ^ pinLast_q[4:1];

always @* begin
	modemChg_d = modemChg_q;
	if (statusRead)
		modemChg_d = 4'h0;
	// A change in the read cycle survives the clear
	if (modemMode)
		modemChg_d = modemChg_d | modemEdge;
end

always @(posedge clk) begin
	if (sys_rst)
		modemChg_q <= 4'h0;
	else
		modemChg_q <= modemChg_d;
end

// ==========================================================================
// APB read data and error
always @(posedge clk) begin
	if (sys_rst) begin
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end else if (setupPhase) begin
		pslverr <= ~addrMapped;
		prdata <= 32'h00000000;
		case (paddr)
			`ULM_OFF_LINECFG: begin
				prdata[`ULM_LINE_MODE_MSB:`ULM_LINE_MODE_LSB] <= lineMode_q;
				prdata[`ULM_CHAN_MODE_MSB:`ULM_CHAN_MODE_LSB] <= chanMode_q;
			end
			`ULM_OFF_STATUS: begin
				prdata[`ULM_ST_TXDONE] <= engineTxAllDone;
				// Flags seen now plus any set during this setup cycle
				prdata[`ULM_ST_CHG_LSB+3:`ULM_ST_CHG_LSB] <= modemChg_d;
				prdata[`ULM_ST_LVL_LSB+3:`ULM_ST_LVL_LSB] <= modemSync;
			end
			`ULM_OFF_BAUD: prdata[DIVISOR_WIDTH-1:0] <= baud_q;
			`ULM_OFF_RATIO: prdata[10:0] <= ratio_q;
			`ULM_OFF_IRFILT: prdata[FILTER_WIDTH-1:0] <= irFilter_q;
			default: prdata <= 32'h00000000;
		endcase
	end
end

// ==========================================================================
// Bit timing derived from the divisor
wire [CNT_WIDTH-1:0] bitCycles = {baud_q, 4'h0};
wire [CNT_WIDTH-1:0] pulseCycles = {2'b00, baud_q, 2'b00} - {4'h0, baud_q};
wire baudRunning = (baud_q != {DIVISOR_WIDTH{1'b0}});

// ==========================================================================
// Infrared modulator
reg [CNT_WIDTH-1:0] modPhase_q;
reg txLast_q;
reg irPulse_q;
wire txFall = txLast_q & ~engineTxLine;
wire modWrap = (modPhase_q >= bitCycles - {{(CNT_WIDTH-1){1'b0}}, 1'b1});

always @(posedge clk) begin
	if (sys_rst) begin
		modPhase_q <= {CNT_WIDTH{1'b0}};
		txLast_q <= 1'b1;
		irPulse_q <= 1'b0;
	end else begin
		txLast_q <= engineTxLine;
		// Start edge aligns the phase to the bit grid
		if (txFall || modWrap)
			modPhase_q <= {CNT_WIDTH{1'b0}};
		else
			modPhase_q <= modPhase_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		if (!irdaMode || !baudRunning)
			irPulse_q <= 1'b0;
		else if (txFall)
			irPulse_q <= 1'b1;
		else if (modWrap)
			irPulse_q <= ~engineTxLine;
		else if (modPhase_q >= pulseCycles - {{(CNT_WIDTH-1){1'b0}}, 1'b1})
			irPulse_q <= 1'b0;
	end
end

// ==========================================================================
// Infrared demodulator
reg [FILTER_WIDTH-1:0] filtCnt_q;
reg filtRun_q;
reg [CNT_WIDTH-1:0] lowCnt_q;
reg demodLow_q;
wire rxFallSeen = pinLast_q[0] & ~rxSync;
wire rxRiseSeen = ~pinLast_q[0] & rxSync;

always @(posedge clk) begin
	if (sys_rst) begin
		filtCnt_q <= {FILTER_WIDTH{1'b0}};
		filtRun_q <= 1'b0;
		lowCnt_q <= {CNT_WIDTH{1'b0}};
		demodLow_q <= 1'b0;
	end else begin
		if (!irdaMode || rxRiseSeen) begin
			filtRun_q <= 1'b0;
			filtCnt_q <= irFilter_q;
		end else if (rxFallSeen) begin
			filtRun_q <= 1'b1;
			filtCnt_q <= irFilter_q;
		end else if (filtRun_q) begin
			if (filtCnt_q == {FILTER_WIDTH{1'b0}})
				filtRun_q <= 1'b0;
			else
				filtCnt_q <= filtCnt_q - {{(FILTER_WIDTH-1){1'b0}}, 1'b1};
		end
		// Expired filter holds the receiver low for one bit
		if (irdaMode && filtRun_q && !rxRiseSeen && filtCnt_q == {FILTER_WIDTH{1'b0}}) begin
			demodLow_q <= 1'b1;
			lowCnt_q <= bitCycles;
		end else if (!irdaMode || lowCnt_q <= {{(CNT_WIDTH-1){1'b0}}, 1'b1}) begin
			demodLow_q <= 1'b0;
			lowCnt_q <= {CNT_WIDTH{1'b0}};
		end else begin
			lowCnt_q <= lowCnt_q - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end
end

// ==========================================================================
// Line selection and channel routing
wire lineTx = irdaMode ? irPulse_q : engineTxLine;
wire lineRx = irdaMode ? ~demodLow_q : rxSync;

always @(posedge clk) begin
	if (sys_rst) begin
		txdPin <= 1'b1;
		engineRxLine <= 1'b1;
		engineDisable <= 1'b0;
	end else begin
		engineDisable <= 1'b0;
		case (chanMode_q)
			`ULM_CHAN_ECHO: begin
				txdPin <= rxSync;
				engineRxLine <= lineRx;
			end
			`ULM_CHAN_LOCAL: begin
				txdPin <= 1'b1;
				engineRxLine <= engineTxLine;
			end
			`ULM_CHAN_REMOTE: begin
				txdPin <= rxSync;
				engineRxLine <= 1'b1;
				engineDisable <= 1'b1;
			end
			default: begin
				txdPin <= lineTx;
				engineRxLine <= lineRx;
			end
		endcase
	end
end

// ==========================================================================
// Request-to-send, terminal-ready and clear-to-send gating
always @(posedge clk) begin
	if (sys_rst) begin
		rtsPin <= 1'b1;
		dtrPin <= 1'b1;
		engineTxInhibit <= 1'b0;
	end else begin
		dtrPin <= dtrLevel_q;
		// All-done stays low through the timeguard, so this holds too
		if (rs485Mode)
			rtsPin <= ~engineTxAllDone;
		else if (modemMode)
			rtsPin <= ~engineTxEnabled;
		else
			rtsPin <= rtsCmd_q;
		// Engine finishes the character in flight before stopping
		engineTxInhibit <= modemMode & modemSync[3];
	end
end

endmodule

// ### tb/ulm_line_modes_properties.sv
// Assertions on the line-mode block ports.
// Assumes whole-word APB writes; line config is mirrored from the bus.
`timescale 1ns/1ps
module ulm_line_modes_properties #(
	parameter DIVISOR_WIDTH = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire engineTxAllDone,
	input wire engineRxLine,
	input wire engineTxInhibit,
	input wire engineDisable,
	input wire [DIVISOR_WIDTH-1:0] baudDivisor,
	input wire rxdPin,
	input wire ctsPin,
	input wire txdPin,
	input wire rtsPin,
	input wire dtrPin
);
// ==========
// Bus mirror and run lengths
logic [31:0] cfg_q;
logic [3:0] age_q;
logic [15:0] hiRun_q;
logic [15:0] loRun_q;
wire wr = psel & penable & pwrite;
wire [3:0] lineMode = cfg_q[3:0];
wire [1:0] chan = cfg_q[15:14];
// Pin paths take three edges, so a fresh mode is judged later
wire settled = age_q > 4'h4;
wire irNormal = settled && lineMode == 4'h8 && chan == 2'h0;
always @(posedge clk) begin
	if (sys_rst) begin
		cfg_q <= 32'h0;
		age_q <= 4'h0;
	end else if (wr && paddr == 8'h04) begin
		cfg_q <= pwdata;
		age_q <= 4'h0;
	end else if (age_q != 4'hF) begin
		age_q <= age_q + 4'h1;
	end
	hiRun_q <= txdPin ? hiRun_q + 16'h1 : 16'h0;
	loRun_q <= engineRxLine ? 16'h0 : loRun_q + 16'h1;
end
// ==========
// Properties
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
sequence dtrOnWr;
	wr && paddr == 8'h00 && pwdata[16] && !pwdata[17];
endsequence
sequence dtrOffWr;
	wr && paddr == 8'h00 && pwdata[17];
endsequence
normal_rx_a: assert property (settled && chan < 2'h2 && lineMode != 4'h8
	|-> engineRxLine == $past(rxdPin, 3)) else $error("receive path");
echo_path_a: assert property (settled && chan[0]
	|-> txdPin == $past(rxdPin, 3)) else $error("echo path");
remote_off_a: assert property (settled
	|-> engineDisable == (chan == 2'h3)) else $error("engine disable");
rs485_rts_a: assert property (settled && lineMode == 4'h1
	|-> rtsPin == !$past(engineTxAllDone)) else $error("line driver enable");
cts_stop_a: assert property (settled && lineMode == 4'h3
	|-> engineTxInhibit == $past(ctsPin, 3)) else $error("clear to send");
// Command lands at the access edge, the pin register one edge later
dtr_on_a: assert property (dtrOnWr |-> ##2 !dtrPin) else $error("dtr on");
dtr_off_a: assert property (dtrOffWr |-> ##2 dtrPin) else $error("dtr off");
ir_pulse_a: assert property (irNormal && $fell(txdPin)
	|-> hiRun_q == 3 * baudDivisor) else $error("pulse width");
ir_filter_a: assert property (irNormal && $rose(engineRxLine)
	|-> loRun_q == 16 * baudDivisor) else $error("demodulated bit");
endmodule

bind ulm_line_modes ulm_line_modes_properties #(.DIVISOR_WIDTH(DIVISOR_WIDTH)) chk (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .engineTxAllDone(engineTxAllDone),
	.engineRxLine(engineRxLine), .engineTxInhibit(engineTxInhibit),
	.engineDisable(engineDisable), .baudDivisor(baudDivisor), .rxdPin(rxdPin),
	.ctsPin(ctsPin), .txdPin(txdPin), .rtsPin(rtsPin), .dtrPin(dtrPin));

// ### tb/ulm_far_side.sv
// Far-side model: modem or infrared transceiver driving the input pins.
// Assumes the bench requests levels; pins move only at a clock edge.
`timescale 1ns/1ps
module ulm_far_side (
	input wire clk,
	input wire [4:0] lineReq,
	output logic rxdPin,
	output logic riPin,
	output logic dsrPin,
	output logic dcdPin,
	output logic ctsPin
);
// ==========
// Pin drive
initial {ctsPin, dcdPin, dsrPin, riPin, rxdPin} = 5'h01;
always @(posedge clk) begin
	{ctsPin, dcdPin, dsrPin, riPin, rxdPin} <= lineReq;
end
endmodule

// ### tb/tb.sv
// Self-checking bench for the line-mode block.
// Assumes the checker binds itself and the far-side model drives the pins.
`timescale 1ns/1ps
module tb;
// ==========
// Signals
logic clk = 1'b0;
logic sysRst = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic txLine = 1'b1;
logic allDone = 1'b1;
logic txEn = 1'b0;
logic [4:0] req = 5'h01;
wire pready, pslverr, rxLine, inhibit, engOff, rxd, ri, dsr, dcd, cts, txd, rts, dtr;
wire [31:0] prdata;
wire [15:0] divisor;
logic [31:0] rd;
logic er;
int badCount = 0;
int checksDone = 0;
always #50 clk = ~clk;
ulm_far_side far (.clk(clk), .lineReq(req), .rxdPin(rxd), .riPin(ri), .dsrPin(dsr),
	.dcdPin(dcd), .ctsPin(cts));
ulm_line_modes DUT (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .engineTxLine(txLine), .engineTxAllDone(allDone),
	.engineTxEnabled(txEn), .engineRxLine(rxLine), .engineTxInhibit(inhibit),
	.engineDisable(engOff), .baudDivisor(divisor), .clockRatio(), .rxdPin(rxd),
	.riPin(ri), .dsrPin(dsr), .dcdPin(dcd), .ctsPin(cts), .txdPin(txd), .rtsPin(rts),
	.dtrPin(dtr));
// ==========
// Shared tasks
task chk(input logic [31:0] got, input logic [31:0] exp);
	checksDone++;
	if (got !== exp) begin
		badCount++;
		$display("BAD %0t got %h want %h", $time, got, exp);
	end
endtask
task final_report;
	$display("checks %0d mismatches %0d", checksDone, badCount);
	if (badCount == 0 && checksDone > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
task cyc(input int n);
	repeat (n) @(posedge clk);
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	@(posedge clk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk);
	penable <= 1'b1;
	n = 0;
	do begin
		@(posedge clk);
		n++;
	end while (pready !== 1'b1 && n < 20);
	if (n >= 20) begin
		badCount++;
		final_report;
	end
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask
// ==========
// Scenarios
task t_regs;
	apb(1'b0, 8'h40, 32'h0);
	chk(rd, 32'h174);
	apb(1'b0, 8'h08, 32'h0);
	chk(er, 1'b1);
	apb(1'b1, 8'h20, 32'h2);
	apb(1'b1, 8'h4C, 32'h5);
	apb(1'b1, 8'h40, 32'h1);
	apb(1'b0, 8'h4C, 32'h0);
	chk(rd, 32'h5);
	chk(divisor, 16'h2);
	$display("registers done");
endtask
task t_chan;
	logic [1:0] m;
	logic p;
	for (int i = 0; i < 8; i++) begin
		m = i[2:1];
		p = i[0];
		apb(1'b1, 8'h04, {16'h0, m, 14'h0});
		req[0] <= p;
		txLine <= !p;
		cyc(7);
		chk(txd, m == 2'h0 ? !p : (m == 2'h2 ? 1'b1 : p));
		if (m != 2'h3)
			chk(rxLine, m == 2'h2 ? !p : p);
		chk(engOff, m == 2'h3);
	end
	txLine <= 1'b1;
	$display("channel modes done");
endtask
task t_rs485;
	apb(1'b1, 8'h04, 32'h1);
	allDone <= 1'b0;
	cyc(3);
	chk(rts, 1'b1);
	cyc(20);
	chk(rts, 1'b1);
	allDone <= 1'b1;
	cyc(3);
	chk(rts, 1'b0);
	$display("line driver done");
endtask
task t_modem;
	apb(1'b1, 8'h04, 32'h3);
	apb(1'b1, 8'h00, 32'h10000);
	cyc(2);
	chk(dtr, 1'b0);
	apb(1'b1, 8'h00, 32'h30000);
	cyc(2);
	chk(dtr, 1'b1);
	txEn <= 1'b1;
	cyc(3);
	chk(rts, 1'b0);
	apb(1'b0, 8'h14, 32'h0);
	req <= 5'h1F;
	cyc(6);
	chk(inhibit, 1'b1);
	apb(1'b0, 8'h14, 32'h0);
	chk(rd[23:16], 8'hFF);
	apb(1'b0, 8'h14, 32'h0);
	chk(rd[19:16], 4'h0);
	req <= 5'h01;
	txEn <= 1'b0;
	cyc(6);
	chk(inhibit, 1'b0);
	chk(rts, 1'b1);
	$display("modem done");
endtask
task t_irda;
	int n;
	int lows;
	apb(1'b1, 8'h04, 32'h8);
	cyc(6);
	chk(txd, 1'b0);
	// Transmit direction only, receiver side left quiet
	txLine <= 1'b0;
	n = 0;
	while (txd !== 1'b1 && n < 10) begin
		@(posedge clk);
		n++;
	end
	n = 0;
	while (txd === 1'b1 && n < 100) begin
		@(posedge clk);
		n++;
	end
	chk(n, 32'h6);
	// Back to one before the next bit, else that zero bit pulses again
	txLine <= 1'b1;
	cyc(26);
	chk(txd, 1'b0);
	// Glitch shorter than the filter, then a real pulse
	for (int len = 3; len < 11; len += 7) begin
		lows = 0;
		req[0] <= 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			if (i == len - 1)
				req[0] <= 1'b1;
			if (rxLine === 1'b0)
				lows++;
		end
		chk(lows, len > 5 ? 32'h20 : 32'h0);
	end
	$display("infrared done");
endtask
// ==========
// Main sequence
initial begin
	repeat (6) @(posedge clk);
	sysRst <= 1'b0;
	t_regs;
	t_chan;
	t_rs485;
	t_modem;
	t_irda;
	final_report;
end
endmodule
